// [rmc_cfg_bank.sv]
// Modem, radio-state and loop configuration register bank with decode.
// Assumes the serial port logic supplies address/strobes on i_clk and the
// radio core supplies status on i_clk; outputs are registered settings.
//
// Functional notes
// - deviation from exponent and mantissa fields
// - clear channel indication per 2-bit select
// - next state after receive per select
// - next state after transmit per select
// - autocal timing per 2-bit select
// - chip ready after counted ripple expiries
// - pin control enable bit, reset clear
// - force oscillator on during sleep
// - loops frozen until carrier sense, if gated
// - offset gain before sync K to 4K
// - offset gain after sync same or K/2
// - offset compensation saturation limit select
// - integral gain before sync one to four
// - proportional gain before sync one to four
// - integral gain after sync same or half
// - proportional gain after sync same or base
// - rate offset limit select
// - exclude top digital gain steps
// - front amplifier gain cap select
// - amplitude target 24 to 42 dB
`timescale 1ns/100ps
`default_nettype none
module rmc_cfg_bank
  import rmc_pkg::*;
(
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_reset_n,
  // Register port
  input wire logic [5:0] i_addr,
  input wire logic i_wr,
  input wire logic [7:0] i_wdata,
  output logic [7:0] o_rdata,
  // Radio status
  input wire logic i_rssi_below,
  input wire logic i_receiving,
  input wire logic i_carrier_sense,
  input wire logic i_sync_found,
  input wire logic i_rx_done,
  input wire logic i_tx_done,
  input wire logic i_xosc_stable,
  input wire logic i_ripple_expire,
  input wire logic [2:0] i_state,
  input wire logic i_state_auto,
  input wire logic i_calibrate_strobe,
  // Derived controls
  output logic o_clear_channel,
  output logic [2:0] o_after_rx_state,
  output logic [2:0] o_after_tx_state,
  output logic o_tx_preamble,
  output logic o_calibrate,
  output logic o_chip_ready_n,
  output logic o_pin_ctrl_en,
  output logic o_xosc_force_on,
  output logic o_loops_freeze,
  output logic [3:0] o_offset_gain_x2,
  output logic [1:0] o_offset_comp_limit,
  output logic [3:0] o_clkrec_int_x2,
  output logic [2:0] o_clkrec_prop,
  output logic [1:0] o_rate_offset_limit,
  output logic [1:0] o_digital_gain_cap,
  output logic [2:0] o_front_amp_gain_cap,
  output logic [5:0] o_amplitude_target,
  output logic [13:0] o_dev_steps
);
  logic [7:0] dev_q, rxto_q, pend_q, cal_q, foc_q, bs_q, gain_q;
  logic [7:0] rdata_next;
  // Write decode; unmapped offsets enable nothing, so such writes vanish
  wire we_dev = i_wr && i_addr == RMC_OFS_DEV;
  wire we_rxto = i_wr && i_addr == RMC_OFS_RXTO;
  wire we_pend = i_wr && i_addr == RMC_OFS_PKTEND;
  wire we_cal = i_wr && i_addr == RMC_OFS_CALPWR;
  wire we_foc = i_wr && i_addr == RMC_OFS_FOC;
  wire we_bs = i_wr && i_addr == RMC_OFS_BSYNC;
  wire we_gain = i_wr && i_addr == RMC_OFS_GAIN;
  // Register instances
  rmc_reg #(.MASK(RMC_MSK_DEV), .RST(RMC_RST_DEV)) u_dev (
    .i_clk(i_clk),
    .i_reset_n(i_reset_n),
    .i_we(we_dev),
    .i_wdata(i_wdata),
    .o_q(dev_q)
  );
  rmc_reg #(.MASK(RMC_MSK_RXTO), .RST(RMC_RST_RXTO)) u_rxto (
    .i_clk(i_clk),
    .i_reset_n(i_reset_n),
    .i_we(we_rxto),
    .i_wdata(i_wdata),
    .o_q(rxto_q)
  );
  rmc_reg #(.MASK(RMC_MSK_PKTEND), .RST(RMC_RST_PKTEND)) u_pend (
    .i_clk(i_clk),
    .i_reset_n(i_reset_n),
    .i_we(we_pend),
    .i_wdata(i_wdata),
    .o_q(pend_q)
  );
  rmc_reg #(.MASK(RMC_MSK_CALPWR), .RST(RMC_RST_CALPWR)) u_cal (
    .i_clk(i_clk),
    .i_reset_n(i_reset_n),
    .i_we(we_cal),
    .i_wdata(i_wdata),
    .o_q(cal_q)
  );
  rmc_reg #(.MASK(RMC_MSK_FOC), .RST(RMC_RST_FOC)) u_foc (
    .i_clk(i_clk),
    .i_reset_n(i_reset_n),
    .i_we(we_foc),
    .i_wdata(i_wdata),
    .o_q(foc_q)
  );
  rmc_reg #(.MASK(RMC_MSK_BSYNC), .RST(RMC_RST_BSYNC)) u_bs (
    .i_clk(i_clk),
    .i_reset_n(i_reset_n),
    .i_we(we_bs),
    .i_wdata(i_wdata),
    .o_q(bs_q)
  );
  rmc_reg #(.MASK(RMC_MSK_GAIN), .RST(RMC_RST_GAIN)) u_gain (
    .i_clk(i_clk),
    .i_reset_n(i_reset_n),
    .i_we(we_gain),
    .i_wdata(i_wdata),
    .o_q(gain_q)
  );

  // Readback; reserved bits already masked at store
  always_comb begin
    unique case (i_addr)
      RMC_OFS_DEV: rdata_next = dev_q;
      RMC_OFS_RXTO: rdata_next = rxto_q;
      RMC_OFS_PKTEND: rdata_next = pend_q;
      RMC_OFS_CALPWR: rdata_next = cal_q;
      RMC_OFS_FOC: rdata_next = foc_q;
      RMC_OFS_BSYNC: rdata_next = bs_q;
      RMC_OFS_GAIN: rdata_next = gain_q;
      default: rdata_next = 8'h00;
    endcase
  end

  // Field extraction
  wire [2:0] dev_e = dev_q[RMC_DEV_E_LSB +: 3];
  wire [2:0] dev_m = dev_q[2:0];
  wire [1:0] cca_sel = pend_q[RMC_CCA_LSB +: 2];
  wire [1:0] rx_sel = pend_q[RMC_AFTRX_LSB +: 2];
  wire [1:0] tx_sel = pend_q[RMC_AFTTX_LSB +: 2];
  wire [1:0] acal_sel = cal_q[RMC_AUTOCAL_LSB +: 2];
  wire [1:0] pwr_sel = cal_q[RMC_PWRUP_LSB +: 2];
  wire [1:0] fpre = foc_q[RMC_FPRE_LSB +: 2];
  wire [1:0] kipre = bs_q[RMC_KI_LSB +: 2];
  wire [1:0] kppre = bs_q[RMC_KP_LSB +: 2];

  // Deviation in units of fxosc/2^17: (8+M) shifted by E
  // Shift happens at full width: the top setting needs 11 bits, and a
  // narrow operand would silently lose the upper steps
  wire [13:0] dev_steps = {10'h000, 1'b1, dev_m} << dev_e;

  // Clear channel
  wire cca_next = (cca_sel == 2'h0) ? 1'b1 :
                  (cca_sel == 2'h1) ? i_rssi_below :
                  (cca_sel == 2'h2) ? !i_receiving :
                  (i_rssi_below && !i_receiving);

  // Select encoding to radio state codes
  function automatic logic [2:0] rmc_rx_map(input logic [1:0] s);
    unique case (s)
      2'h0: rmc_rx_map = RMC_ST_IDLE;
      2'h1: rmc_rx_map = RMC_ST_TXSYNTH;
      2'h2: rmc_rx_map = RMC_ST_TX;
      default: rmc_rx_map = RMC_ST_RX;
    endcase
  endfunction : rmc_rx_map
  function automatic logic [2:0] rmc_tx_map(input logic [1:0] s);
    unique case (s)
      2'h0: rmc_tx_map = RMC_ST_IDLE;
      2'h1: rmc_tx_map = RMC_ST_TXSYNTH;
      2'h2: rmc_tx_map = RMC_ST_TX;
      default: rmc_tx_map = RMC_ST_RX;
    endcase
  endfunction : rmc_tx_map

  // Autocalibration: track idle exits and automatic returns
  logic [2:0] state_reg;
  logic [1:0] ret_cnt_reg;
  logic cal_reg;
  wire leave_idle = state_reg == RMC_ST_IDLE && i_state != RMC_ST_IDLE;
  wire auto_ret = state_reg != RMC_ST_IDLE && i_state == RMC_ST_IDLE &&
                  i_state_auto;
  wire cal_next = i_calibrate_strobe ||
                  (acal_sel == 2'h1 && leave_idle) ||
                  (acal_sel == 2'h2 && auto_ret) ||
                  (acal_sel == 2'h3 && auto_ret &&
                   ret_cnt_reg == 2'h3);

  // Power-up wait: count ripple expiries once oscillator is stable
  logic [2:0] xs_sync_reg;
  logic [8:0] pwr_cnt_reg;
  logic rdy_n_reg;
  wire xs_ok = xs_sync_reg[1] && xs_sync_reg[2];
  wire [8:0] pwr_target = (pwr_sel == 2'h0) ? RMC_PWR_CNT0 :
                          (pwr_sel == 2'h1) ? RMC_PWR_CNT1 :
                          (pwr_sel == 2'h2) ? RMC_PWR_CNT2 : RMC_PWR_CNT3;
  wire pwr_done = pwr_cnt_reg >= pwr_target;

  // Loop gains; x2 scaling keeps K/2 integral
  // 4K is 8 in half-K units, so four bits are needed here
  wire [3:0] foc_pre_x2 = {1'b0, fpre, 1'b0} + 4'h2;
  wire [3:0] foc_gain = (i_sync_found && foc_q[RMC_FPOST_BIT]) ?
                        4'h1 : foc_pre_x2;
  wire [3:0] ki_pre_x2 = {1'b0, kipre, 1'b0} + 4'h2;
  wire [3:0] ki_gain = (i_sync_found && bs_q[RMC_KIPOST_BIT]) ?
                       4'h1 : ki_pre_x2;
  wire [2:0] kp_pre = {1'b0, kppre} + 3'h1;
  wire [2:0] kp_gain = (i_sync_found && bs_q[RMC_KPPOST_BIT]) ?
                       3'h1 : kp_pre;

  // Target table in dB
  wire [2:0] tsel = gain_q[RMC_TGT_LSB +: 3];
  wire [5:0] tgt_db = (tsel < 3'h5) ? 6'(6'h18 + 6'(tsel) * 6'h3) :
                      6'(6'h26 + 6'(tsel - 3'h5) * 6'h2);

  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      state_reg <= RMC_ST_IDLE;
      ret_cnt_reg <= 2'h0;
      cal_reg <= 1'b0;
      xs_sync_reg <= 3'h0;
      pwr_cnt_reg <= 9'h000;
      rdy_n_reg <= 1'b1;
    end else begin
      state_reg <= i_state;
      if (auto_ret) begin
        ret_cnt_reg <= ret_cnt_reg + 2'h1;
      end
      cal_reg <= cal_next;
      xs_sync_reg <= {xs_sync_reg[1:0], i_xosc_stable};
      if (!xs_ok) begin
        pwr_cnt_reg <= 9'h000;
        rdy_n_reg <= 1'b1;
      end else if (pwr_done) begin
        rdy_n_reg <= 1'b0;
      end else if (i_ripple_expire) begin
        pwr_cnt_reg <= pwr_cnt_reg + 9'h001;
      end
    end
  end

  // Registered output stage
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_rdata <= 8'h00;
      o_clear_channel <= 1'b0;
      o_after_rx_state <= RMC_ST_IDLE;
      o_after_tx_state <= RMC_ST_IDLE;
      o_tx_preamble <= 1'b0;
      o_pin_ctrl_en <= 1'b0;
      o_xosc_force_on <= 1'b0;
      o_loops_freeze <= 1'b0;
      o_offset_gain_x2 <= 4'h0;
      o_offset_comp_limit <= 2'h0;
      o_clkrec_int_x2 <= 4'h0;
      o_clkrec_prop <= 3'h0;
      o_rate_offset_limit <= 2'h0;
      o_digital_gain_cap <= 2'h0;
      o_front_amp_gain_cap <= 3'h0;
      o_amplitude_target <= 6'h00;
      o_dev_steps <= 14'h0000;
    end else begin
      o_rdata <= rdata_next;
      o_clear_channel <= cca_next;
      // Only sampled by the radio core on packet end
      o_after_rx_state <= rmc_rx_map(rx_sel);
      o_after_tx_state <= rmc_tx_map(tx_sel);
      o_tx_preamble <= i_tx_done && tx_sel == 2'h2;
      o_pin_ctrl_en <= cal_q[RMC_PINCTL_BIT];
      o_xosc_force_on <= cal_q[RMC_XOSC_BIT];
      o_loops_freeze <= foc_q[RMC_GATE_BIT] && !i_carrier_sense;
      o_offset_gain_x2 <= foc_gain;
      o_offset_comp_limit <= foc_q[RMC_FLIM_LSB +: 2];
      o_clkrec_int_x2 <= ki_gain;
      o_clkrec_prop <= kp_gain;
      o_rate_offset_limit <= bs_q[RMC_RLIM_LSB +: 2];
      o_digital_gain_cap <= gain_q[RMC_DGC_LSB +: 2];
      o_front_amp_gain_cap <= gain_q[RMC_LNA_LSB +: 3];
      o_amplitude_target <= tgt_db;
      o_dev_steps <= dev_steps;
    end
  end
  assign o_calibrate = cal_reg;
  assign o_chip_ready_n = rdy_n_reg;
  // i_rx_done is only a qualifier upstream; kept for port completeness
  wire unused_ok = i_rx_done;
endmodule : rmc_cfg_bank
`default_nettype wire

// [rmc_pkg.sv]
// Register map, field positions and reset values of the modem/loop config bank.
// Assumes an 8-bit register port driven by the serial interface logic.
package rmc_pkg;
  localparam logic [5:0] RMC_OFS_DEV = 6'h15;
  localparam logic [5:0] RMC_OFS_RXTO = 6'h16;
  localparam logic [5:0] RMC_OFS_PKTEND = 6'h17;
  localparam logic [5:0] RMC_OFS_CALPWR = 6'h18;
  localparam logic [5:0] RMC_OFS_FOC = 6'h19;
  localparam logic [5:0] RMC_OFS_BSYNC = 6'h1a;
  localparam logic [5:0] RMC_OFS_GAIN = 6'h1b;
  // Writable-bit masks; cleared bits are reserved and read zero
  localparam logic [7:0] RMC_MSK_DEV = 8'h77;
  localparam logic [7:0] RMC_MSK_RXTO = 8'h1f;
  localparam logic [7:0] RMC_MSK_PKTEND = 8'h3f;
  localparam logic [7:0] RMC_MSK_CALPWR = 8'h3f;
  localparam logic [7:0] RMC_MSK_FOC = 8'h3f;
  localparam logic [7:0] RMC_MSK_BSYNC = 8'hff;
  localparam logic [7:0] RMC_MSK_GAIN = 8'hff;
  // Reset values
  localparam logic [7:0] RMC_RST_DEV = 8'h47;
  localparam logic [7:0] RMC_RST_RXTO = 8'h07;
  localparam logic [7:0] RMC_RST_PKTEND = 8'h30;
  localparam logic [7:0] RMC_RST_CALPWR = 8'h04;
  localparam logic [7:0] RMC_RST_FOC = 8'h36;
  localparam logic [7:0] RMC_RST_BSYNC = 8'h6c;
  localparam logic [7:0] RMC_RST_GAIN = 8'h03;
  // Field positions
  localparam int RMC_DEV_E_LSB = 4;
  localparam int RMC_CCA_LSB = 4;
  localparam int RMC_AFTRX_LSB = 2;
  localparam int RMC_AFTTX_LSB = 0;
  localparam int RMC_AUTOCAL_LSB = 4;
  localparam int RMC_PWRUP_LSB = 2;
  localparam int RMC_PINCTL_BIT = 1;
  localparam int RMC_XOSC_BIT = 0;
  localparam int RMC_GATE_BIT = 5;
  localparam int RMC_FPRE_LSB = 3;
  localparam int RMC_FPOST_BIT = 2;
  localparam int RMC_FLIM_LSB = 0;
  localparam int RMC_KI_LSB = 6;
  localparam int RMC_KP_LSB = 4;
  localparam int RMC_KIPOST_BIT = 3;
  localparam int RMC_KPPOST_BIT = 2;
  localparam int RMC_RLIM_LSB = 0;
  localparam int RMC_DGC_LSB = 6;
  localparam int RMC_LNA_LSB = 3;
  localparam int RMC_TGT_LSB = 0;
  // Ripple counter expiries per power-up wait setting
  localparam logic [8:0] RMC_PWR_CNT0 = 9'h001;
  localparam logic [8:0] RMC_PWR_CNT1 = 9'h010;
  localparam logic [8:0] RMC_PWR_CNT2 = 9'h040;
  localparam logic [8:0] RMC_PWR_CNT3 = 9'h100;
  // Radio states
  typedef enum logic [2:0] {
    RMC_ST_IDLE = 3'h0,
    RMC_ST_RX = 3'h1,
    RMC_ST_TXSYNTH = 3'h3,
    RMC_ST_TX = 3'h2
  } rmc_state_t;
endpackage : rmc_pkg

// [rmc_reg.sv]
// One masked 8-bit configuration register.
// Assumes write strobe and data are synchronous to i_clk.
`timescale 1ns/100ps
`default_nettype none
module rmc_reg
  import rmc_pkg::*;
#(
  parameter logic [7:0] MASK = 8'hff,
  parameter logic [7:0] RST = 8'h00
) (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_reset_n,
  // Write port
  input wire logic i_we,
  input wire logic [7:0] i_wdata,
  // Stored value
  output logic [7:0] o_q
);
  logic [7:0] q_reg;
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      q_reg <= RST & MASK;
    end else if (i_we) begin
      q_reg <= i_wdata & MASK;
    end
  end
  assign o_q = q_reg;
endmodule : rmc_reg
`default_nettype wire

// [rmc_host_model.sv]
// Host side of the byte port: register writes and registered reads.
// Assumes the bench calls its tasks from one process on i_clk.
`timescale 1ns/100ps
`default_nettype none
module rmc_host_model (
  // Clock
  input wire logic i_clk,
  // Register port
  output logic [5:0] o_addr,
  output logic o_wr,
  output logic [7:0] o_wdata,
  input wire logic [7:0] i_rdata
);
  initial begin
    o_addr = 6'h00;
    o_wr = 1'b0;
    o_wdata = 8'h00;
  end
  // Callers never pair a transmit-type after-receive state with clear
  // channel use, and keep the offset limit at zero under on-off keying
  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    @(posedge i_clk);
    o_addr <= a;
    o_wr <= 1'b1;
    o_wdata <= d;
    @(posedge i_clk);
    o_wr <= 1'b0;
  endtask : wr
  // Released data is inverted so a stale byte is never mistaken for valid
  task automatic rd(input logic [5:0] a, output logic [7:0] d);
    @(posedge i_clk);
    o_addr <= a;
    o_wr <= 1'b0;
    o_wdata <= ~o_wdata;
    repeat (2) @(posedge i_clk);
    d = i_rdata;
  endtask : rd
endmodule : rmc_host_model
`default_nettype wire

// [rmc_cfg_bank_checker.sv]
// Checker of the config bank: read path, derived controls, ready.
// Assumes it is bound to rmc_cfg_bank and sees only its ports.
`timescale 1ns/100ps
`default_nettype none
module rmc_cfg_bank_checker
  import rmc_pkg::*;
(
  // Clock, reset and register port
  input wire logic i_clk,
  input wire logic i_reset_n,
  input wire logic [5:0] i_addr,
  input wire logic i_wr,
  input wire logic [7:0] i_wdata,
  input wire logic [7:0] o_rdata,
  // Status and derived controls
  input wire logic i_carrier_sense,
  input wire logic i_tx_done,
  input wire logic i_xosc_stable,
  input wire logic o_tx_preamble,
  input wire logic o_calibrate,
  input wire logic o_chip_ready_n,
  input wire logic o_loops_freeze,
  input wire logic [3:0] o_clkrec_int_x2,
  input wire logic [5:0] o_amplitude_target
);
  logic [5:0] addr_q;
  logic [7:0] msk;
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_reset_n);
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n)
      addr_q <= 6'h00;
    else
      addr_q <= i_addr;
  end
  // Unmapped places have no writable bit at all
  assign msk = (addr_q < 6'h15 || addr_q > 6'h1b) ? 8'h00 :
    (addr_q == 6'h15) ? 8'h77 : (addr_q == 6'h16) ? 8'h1f :
    (addr_q > 6'h19) ? 8'hff : 8'h3f;
  sequence s_wr_gain;
    i_wr && i_addr == RMC_OFS_GAIN;
  endsequence
  sequence s_rd_gain;
    !i_wr && i_addr == RMC_OFS_GAIN;
  endsequence
  a_reserved_read_zero: assert property ((o_rdata & ~msk) == 8'h00)
    else $error("reserved or unmapped bits read nonzero");
  a_gain_readback: assert property (s_wr_gain ##1 s_rd_gain |=>
    o_rdata == $past(i_wdata, 2)) else $error("gain byte readback wrong");
  a_freeze_follows_cs: assert property (o_loops_freeze |->
    !$past(i_carrier_sense)) else $error("loops frozen under carrier");
  a_preamble_cause: assert property (o_tx_preamble |->
    $past(i_tx_done)) else $error("preamble without finished send");
  a_calib_one_cycle: assert property (o_calibrate |=> !o_calibrate)
    else $error("calibrate pulse longer than one cycle");
  a_ready_needs_xosc: assert property ($fell(o_chip_ready_n) |->
    $past(i_xosc_stable, 3)) else $error("ready before oscillator stable");
  a_target_table: assert property ($past(i_reset_n) |->
    o_amplitude_target inside {6'h18, 6'h1b, 6'h1e, 6'h21, 6'h24,
    6'h26, 6'h28, 6'h2a}) else $error("amplitude target off table");
  a_int_gain_set: assert property ($past(i_reset_n) |->
    o_clkrec_int_x2 inside {4'h1, 4'h2, 4'h4, 4'h6, 4'h8})
    else $error("integral gain off table");
endmodule : rmc_cfg_bank_checker
bind rmc_cfg_bank rmc_cfg_bank_checker u_chk (.i_clk, .i_reset_n,
  .i_addr, .i_wr, .i_wdata, .o_rdata, .i_carrier_sense, .i_tx_done,
  .i_xosc_stable, .o_tx_preamble, .o_calibrate, .o_chip_ready_n,
  .o_loops_freeze, .o_clkrec_int_x2, .o_amplitude_target);
`default_nettype wire

// [rmc_cfg_bank_tb_top.sv]
// Self-checking bench of the config bank driven through the host model.
// Assumes the checker binds itself; stimulus is a fixed sequence.
`timescale 1ns/100ps
`default_nettype none
module rmc_cfg_bank_tb_top;
  import rmc_pkg::*;
  typedef struct {logic [5:0] a; logic [7:0] d; logic [7:0] q;} rmc_row_t;
  logic i_clk, i_reset_n, i_rssi_below, i_receiving, i_carrier_sense;
  logic i_sync_found, i_rx_done, i_tx_done, i_xosc_stable, i_wr;
  logic i_ripple_expire, i_state_auto, i_calibrate_strobe, o_calibrate;
  logic o_clear_channel, o_tx_preamble, o_chip_ready_n, o_pin_ctrl_en;
  logic o_xosc_force_on, o_loops_freeze;
  logic [2:0] i_state, o_after_rx_state, o_after_tx_state, o_clkrec_prop;
  logic [2:0] o_front_amp_gain_cap;
  logic [1:0] o_offset_comp_limit, o_rate_offset_limit, o_digital_gain_cap;
  logic [3:0] o_clkrec_int_x2, o_offset_gain_x2;
  logic [5:0] i_addr, o_amplitude_target;
  logic [7:0] i_wdata, o_rdata, rd_val;
  logic [13:0] o_dev_steps;
  int err_total = 0;
  int num_checks = 0;
  rmc_state_t smap [4] = '{RMC_ST_IDLE, RMC_ST_TXSYNTH, RMC_ST_TX, RMC_ST_RX};
  logic [7:0] rst_tab [7] = '{8'h47, 8'h07, 8'h30, 8'h04, 8'h36, 8'h6c, 8'h03};
  logic [5:0] tgt_tab [8] = '{6'h18, 6'h1b, 6'h1e, 6'h21, 6'h24, 6'h26,
    6'h28, 6'h2a};
  rmc_row_t rows [9] = '{'{6'h15, 8'hff, 8'h77}, '{6'h16, 8'hff, 8'h1f},
    '{6'h17, 8'hff, 8'h3f}, '{6'h18, 8'hff, 8'h3f}, '{6'h19, 8'hff, 8'h3f},
    '{6'h1a, 8'h5a, 8'h5a}, '{6'h1b, 8'ha5, 8'ha5}, '{6'h1c, 8'hff, 8'h00},
    '{6'h14, 8'hff, 8'h00}};
  rmc_cfg_bank u_rmc_cfg_bank (.*);
  rmc_host_model u_rmc_host_model (.i_clk, .o_addr(i_addr), .o_wr(i_wr),
    .o_wdata(i_wdata), .i_rdata(o_rdata));
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp) begin
      err_total++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask : chk
  task automatic wrap_up();
    $display("checks %0d errors %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : wrap_up
  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    u_rmc_host_model.wr(a, d);
  endtask : wr
  task automatic rd(input logic [5:0] a);
    u_rmc_host_model.rd(a, rd_val);
  endtask : rd
  task automatic tick(input int n);
    repeat (n) @(posedge i_clk);
  endtask : tick
  // A missed pulse or level ends the run rather than hanging it
  task automatic wait_for(input bit cal);
    int n = 0;
    while ((cal ? o_calibrate : !o_chip_ready_n) !== 1'b1 && n < 8) begin
      tick(1);
      n++;
    end
    chk(n < 8, 1'b1);
    if (n == 8)
      wrap_up();
  endtask : wait_for
  initial begin
    i_clk = 1'b0;
    forever #5 i_clk = ~i_clk;
  end
  initial begin
    tick(20000);
    err_total++;
    wrap_up();
  end
  initial begin
    {i_rssi_below, i_receiving, i_carrier_sense, i_sync_found} = 4'h0;
    {i_rx_done, i_tx_done, i_xosc_stable, i_ripple_expire} = 4'h0;
    {i_state_auto, i_calibrate_strobe, i_reset_n} = 3'h0;
    i_state = RMC_ST_IDLE;
    tick(4);
    chk(o_chip_ready_n, 1'b1);
    i_reset_n <= 1'b1;
    for (int i = 0; i < 7; i++) begin
      rd(6'(6'h15 + i));
      chk(rd_val, rst_tab[i]);
    end
    chk(o_dev_steps, 14'h0f0);
    chk(o_pin_ctrl_en, 1'b0);
    foreach (rows[i]) begin
      wr(rows[i].a, rows[i].d);
      rd(rows[i].a);
      chk(rd_val, rows[i].q);
    end
    for (int e = 0; e < 8; e++) begin
      wr(6'h15, 8'(e * 17));
      rd(6'h15);
      chk(o_dev_steps, 16'((8 + e) << e));
    end
    for (int k = 0; k < 4; k++) begin
      wr(6'h17, 8'(k * 5));
      rd(6'h17);
      chk(o_after_rx_state, smap[k]);
      chk(o_after_tx_state, smap[k]);
    end
    wr(6'h17, 8'h02);
    rd(6'h17);
    i_tx_done <= 1'b1;
    tick(1);
    i_tx_done <= 1'b0;
    #1 chk(o_tx_preamble, 1'b1);
    for (int m = 0; m < 16; m++) begin
      wr(6'h17, 8'((m & 12) * 4));
      i_rssi_below <= m[0];
      i_receiving <= m[1];
      rd(6'h17);
      chk(o_clear_channel, (!m[2] || m[0]) && (!m[3] || !m[1]));
    end
    for (int p = 0; p < 4; p++) begin
      wr(6'h19, 8'(8'h24 | p << 3 | p));
      i_carrier_sense <= p[0];
      i_sync_found <= 1'b0;
      rd(6'h19);
      chk(o_offset_gain_x2, 16'(2 * p + 2));
      chk(o_offset_comp_limit, 16'(p));
      chk(o_loops_freeze, !p[0]);
      i_sync_found <= 1'b1;
      tick(2);
      chk(o_offset_gain_x2, 16'h1);
    end
    for (int p = 0; p < 4; p++) begin
      i_sync_found <= 1'b0;
      wr(6'h1a, 8'(p * 8'h51));
      rd(6'h1a);
      chk(o_clkrec_int_x2, 16'(2 * p + 2));
      chk(o_clkrec_prop, 16'(p + 1));
      chk(o_rate_offset_limit, 16'(p));
      wr(6'h1a, 8'(p * 8'h51 | 8'h0c));
      i_sync_found <= 1'b1;
      rd(6'h1a);
      chk(o_clkrec_int_x2, 16'h1);
      chk(o_clkrec_prop, 16'h1);
    end
    for (int t = 0; t < 8; t++) begin
      wr(6'h1b, 8'(t << 6 | t << 3 | t));
      rd(6'h1b);
      chk(o_digital_gain_cap, 16'(t & 3));
      chk(o_front_amp_gain_cap, 16'(t));
      chk(o_amplitude_target, tgt_tab[t]);
    end
    wr(6'h18, 8'h03);
    rd(6'h18);
    chk(o_pin_ctrl_en, 1'b1);
    chk(o_xosc_force_on, 1'b1);
    wr(6'h18, 8'h10);
    i_xosc_stable <= 1'b1;
    rd(6'h18);
    tick(4);
    chk(o_chip_ready_n, 1'b1);
    i_ripple_expire <= 1'b1;
    tick(1);
    i_ripple_expire <= 1'b0;
    wait_for(1'b0);
    i_state <= RMC_ST_RX;
    wait_for(1'b1);
    wrap_up();
  end
endmodule : rmc_cfg_bank_tb_top
`default_nettype wire
